// *** shared/adc_port_pkg.sv ***
// Shared constants, types and helpers of the converter serial port
package adc_port_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_NS = 20;
	localparam int UPD_NS = 200;
	localparam int CAL_NS = 2000;
	localparam int UPD_CYC = (UPD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] UPD_LOAD = 8'(UPD_CYC - 1);
	localparam logic [7:0] CAL_LOAD = 8'(CAL_CYC - 1);

	// ********************************
	// Widths and register map
	// ********************************
	localparam int REG_W = 24;
	localparam int FIFO_DEPTH = 8;
	localparam logic [4:0] BITS_COMM = 5'h08;
	localparam logic [4:0] BITS_WORD = 5'h18;
	localparam logic [4:0] BITS_MODE = 5'h10;
	localparam logic [2:0] RS_COMM = 3'h0;
	localparam logic [2:0] RS_DATA = 3'h1;
	localparam logic [2:0] RS_MODE = 3'h2;
	localparam logic [2:0] RS_FILT = 3'h3;
	localparam logic [2:0] RS_DAC = 3'h4;
	localparam logic [2:0] RS_OFFS = 3'h5;
	localparam logic [2:0] RS_GAIN = 3'h6;
	localparam int COMM_RD_BIT = 6;
	localparam int MD_LSB = 13;
	localparam int MD_CAL_BIT = 15;
	localparam logic [2:0] MD_IDLE = 3'h0;
	localparam logic [2:0] MD_CONV = 3'h1;
	localparam int STAT_RDY_BIT = 7;
	localparam int STAT_CAL_BIT = 6;
	localparam logic [REG_W-1:0] REG_RST = 24'h000000;

	// Pin vector positions
	localparam int P_CS = 0;
	localparam int P_SCLK = 1;
	localparam int P_DIN = 2;
	localparam int P_STBY = 3;
	localparam logic [3:0] PIN_IDLE = 4'h9;

	typedef struct packed {
		logic standby_n;
		logic din;
		logic sclk;
		logic cs_n;
	} ser_pins_t;

	typedef enum logic [0:0] {PH_COMM, PH_DATA} phase_t;
	typedef enum logic [1:0] {CV_IDLE, CV_UPD, CV_CAL} cv_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic sclk_d;
		phase_t ph;
		logic rd;
		logic [2:0] rs;
		logic [4:0] bit_left;
		logic [REG_W-1:0] sh_in;
		logic [REG_W-1:0] sh_out;
		logic [7:0][REG_W-1:0] regs;
		cv_t cv;
		logic [7:0] cnt;
		logic rdy_n;
		logic dout;
		logic dout_oe_n;
		logic stby;
	} port_state_t;

	function automatic logic [4:0] reg_bits(input logic [2:0] rs);
		case (rs)
			RS_COMM, RS_DAC: reg_bits = BITS_COMM;
			RS_MODE: reg_bits = BITS_MODE;
			default: reg_bits = BITS_WORD;
		endcase
	endfunction

	function automatic logic writable(input logic [2:0] rs);
		writable = (rs != RS_DATA) && (rs <= RS_GAIN);
	endfunction

endpackage

// *** rtl/adc_serial_port.sv ***
// Serial port, ready flag and standby control of the converter
// ********************************
// Word buffer
// ********************************
module conv_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic space;
	} fifo_state_t;
	fifo_state_t s, next_s;
	logic push, pop;

	always_comb begin
		next_s = s;
		push = i_in_valid && s.space;
		pop = i_out_ready && (s.cnt != '0);
		if (push) begin
			next_s.mem[s.wp] = i_in_data;
			next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
		end
		if (pop)
			next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
		next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		// Registered so the source sees a clean ready
		next_s.space = next_s.cnt != (AW+1)'(DEPTH);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s <= '0;
			s.space <= 1'b1;
		end else
			s <= next_s;
	end

	assign o_in_ready = s.space;
	assign o_out_valid = s.cnt != '0;
	assign o_out_data = s.mem[s.rp];

	// ********************************
	// Checks
	// ********************************
	a_fifo_bound: assert property (@(posedge i_clk)
		disable iff (i_srst) s.cnt <= (AW+1)'(DEPTH))
		else $error("word buffer count past its depth");
	// A full buffer must refuse, or a word would be overwritten
	a_fifo_full_hold: assert property (@(posedge i_clk)
		disable iff (i_srst) !s.space |=> s.cnt <= $past(s.cnt))
		else $error("word taken while buffer full");
endmodule

module adc_serial_port (
	input wire logic I_SYS_CLK,
	input wire logic I_SRST,
	input wire adc_port_pkg::ser_pins_t I_SER,
	input wire logic I_CONV_VALID,
	input wire logic [23:0] I_CONV_DATA,
	output logic O_CONV_READY,
	output logic O_DOUT,
	output logic O_DOUT_OE_N,
	output logic O_RDY_N,
	output logic O_POWER_DOWN
);
	adc_port_pkg::port_state_t s, next_s;
	logic stby, sel, rise, fall, last, reading, pop, f_valid;
	logic [23:0] f_data, word;
	logic [23:0] mask;
	logic [7:0] comm;
	logic [4:0] bits;

	conv_fifo #(.WIDTH(adc_port_pkg::REG_W),
		.DEPTH(adc_port_pkg::FIFO_DEPTH)) u_fifo (
		.i_clk(I_SYS_CLK),
		.i_srst(I_SRST),
		.i_in_valid(I_CONV_VALID),
		.i_in_data(I_CONV_DATA),
		.o_in_ready(O_CONV_READY),
		.o_out_valid(f_valid),
		.o_out_data(f_data),
		.i_out_ready(pop)
	);

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		next_s = s;
		pop = 1'b0;
		next_s.s1 = I_SER;
		next_s.s2 = s.s1;
		next_s.sclk_d = s.s2[adc_port_pkg::P_SCLK];
		stby = !s.s2[adc_port_pkg::P_STBY];
		sel = !s.s2[adc_port_pkg::P_CS] && !stby;
		rise = sel && s.s2[adc_port_pkg::P_SCLK] && !s.sclk_d;
		fall = sel && !s.s2[adc_port_pkg::P_SCLK] && s.sclk_d;
		last = s.bit_left == 5'h01;
		word = {s.sh_in[22:0], s.s2[adc_port_pkg::P_DIN]};
		comm = word[7:0];
		bits = adc_port_pkg::reg_bits(s.rs);
		mask = ~(24'hFFFFFF << bits);
		reading = s.ph == adc_port_pkg::PH_DATA && s.rd
			&& s.rs == adc_port_pkg::RS_DATA;
		next_s.stby = stby;
		next_s.dout_oe_n = !sel;
		// Frozen in standby: nothing below runs, so all registers hold except the pin sync, sclk_d, stby and dout_oe_n
		if (!stby) begin
			case (s.cv)
				adc_port_pkg::CV_IDLE: begin
					// Holding off while a data read runs protects the word
					if (s.regs[adc_port_pkg::RS_MODE][adc_port_pkg::MD_LSB+:3]
						== adc_port_pkg::MD_CONV && f_valid && !reading) begin
						next_s.rdy_n = 1'b1;
						next_s.cnt = adc_port_pkg::UPD_LOAD;
						next_s.cv = adc_port_pkg::CV_UPD;
					end
				end
				adc_port_pkg::CV_UPD: begin
					if (s.cnt == 8'h00) begin
						pop = 1'b1;
						next_s.regs[adc_port_pkg::RS_DATA] = f_data;
						next_s.rdy_n = 1'b0;
						next_s.cv = adc_port_pkg::CV_IDLE;
					end else
						next_s.cnt = s.cnt - 8'h01;
				end
				adc_port_pkg::CV_CAL: begin
					if (s.cnt == 8'h00) begin
						next_s.rdy_n = 1'b0;
						next_s.regs[adc_port_pkg::RS_MODE]
							[adc_port_pkg::MD_LSB+:3] = adc_port_pkg::MD_IDLE;
						next_s.cv = adc_port_pkg::CV_IDLE;
					end else
						next_s.cnt = s.cnt - 8'h01;
				end
				default: next_s.cv = adc_port_pkg::CV_IDLE;
			endcase
			// Output changes on the falling edge, host samples mid-high
			if (fall && s.ph == adc_port_pkg::PH_DATA && s.rd) begin
				next_s.dout = s.sh_out[23];
				next_s.sh_out = {s.sh_out[22:0], 1'b0};
			end
			if (rise) begin
				next_s.sh_in = word;
				next_s.bit_left = s.bit_left - 5'h01;
				if (last && s.ph == adc_port_pkg::PH_COMM) begin
					next_s.rd = comm[adc_port_pkg::COMM_RD_BIT];
					next_s.rs = comm[2:0];
					next_s.bit_left = adc_port_pkg::reg_bits(comm[2:0]);
					next_s.ph = adc_port_pkg::PH_DATA;
					// Address zero reads back status, writes go to comm
					if (comm[2:0] == adc_port_pkg::RS_COMM)
						next_s.sh_out = {!s.rdy_n,
							s.cv == adc_port_pkg::CV_CAL, 22'h000000};
					else
						next_s.sh_out = s.regs[comm[2:0]] <<
							(5'(adc_port_pkg::REG_W) - adc_port_pkg::reg_bits(comm[2:0]));
					if (!comm[adc_port_pkg::COMM_RD_BIT])
						next_s.regs[adc_port_pkg::RS_COMM] = {16'h0000, comm};
				end else if (last) begin
					next_s.ph = adc_port_pkg::PH_COMM;
					next_s.bit_left = adc_port_pkg::BITS_COMM;
					if (s.rd && s.rs == adc_port_pkg::RS_DATA)
						next_s.rdy_n = 1'b1;
					if (!s.rd && adc_port_pkg::writable(s.rs)) begin
						next_s.regs[s.rs] = word & mask;
						if (s.rs == adc_port_pkg::RS_MODE
							&& word[adc_port_pkg::MD_CAL_BIT]) begin
							next_s.rdy_n = 1'b1;
							next_s.cnt = adc_port_pkg::CAL_LOAD;
							next_s.cv = adc_port_pkg::CV_CAL;
						end
					end
				end
			end
		end
	end

	// ********************************
	// Registers
	// ********************************
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SRST) begin
			s <= '0;
			s.s1 <= adc_port_pkg::PIN_IDLE;
			s.s2 <= adc_port_pkg::PIN_IDLE;
			s.bit_left <= adc_port_pkg::BITS_COMM;
			s.rdy_n <= 1'b1;
			s.dout_oe_n <= 1'b1;
		end else
			s <= next_s;
	end

	assign O_DOUT = s.dout;
	assign O_DOUT_OE_N = s.dout_oe_n;
	assign O_RDY_N = s.rdy_n;
	assign O_POWER_DOWN = s.stby;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SRST);

	a_stby_power_down: assert property (stby |=> O_POWER_DOWN)
		else $error("standby not flagged");
	a_stby_regs_hold: assert property (stby |=> $stable(s.regs))
		else $error("register changed in standby");
	a_desel_no_shift: assert property (!sel |=> $stable(s.bit_left))
		else $error("clock taken while deselected");
	a_three_wire_shift: assert property (rise |=> $changed(s.bit_left))
		else $error("edge lost with select low");
	a_update_load: assert property (!stby && s.cv == adc_port_pkg::CV_UPD
		&& s.cnt == 8'h00 |=> !O_RDY_N
		&& s.regs[adc_port_pkg::RS_DATA] == $past(f_data))
		else $error("new word not flagged");
	a_read_done_high: assert property (rise && last && reading
		|=> O_RDY_N)
		else $error("ready low after full read");
	a_update_rdy_high: assert property ($rose(s.cv == adc_port_pkg::CV_UPD)
		|-> O_RDY_N [*8])
		else $error("ready low during update");
	a_cal_busy_high: assert property (s.cv == adc_port_pkg::CV_CAL
		|-> O_RDY_N)
		else $error("ready low during calibration");
	a_dout_shift: assert property (fall && s.ph == adc_port_pkg::PH_DATA
		&& s.rd |=> O_DOUT == $past(s.sh_out[23]))
		else $error("wrong output bit");
	a_write_xfer: assert property (rise && last && s.ph == adc_port_pkg::PH_DATA
		&& !s.rd && adc_port_pkg::writable(s.rs)
		|=> s.regs[$past(s.rs)] == $past(word & mask))
		else $error("written word not stored");
	a_float_desel: assert property (!sel |=> O_DOUT_OE_N)
		else $error("output driven while deselected");
	a_drive_sel: assert property (sel |=> !O_DOUT_OE_N)
		else $error("data line floats while selected");

	// Standby lets go of the data line as well
	a_stby_release: assert property (stby |=> O_DOUT_OE_N)
		else $error("data line driven in standby");
	a_stby_frozen: assert property (stby |=> $stable(s.cv)
		&& $stable(s.cnt) && $stable(s.bit_left)
		&& $stable(s.sh_in))
		else $error("state moved in standby");
	a_bit_count: assert property (rise && !last
		|=> s.bit_left == $past(s.bit_left) - 5'h01)
		else $error("bit count skipped an edge");
	// A data register read under way holds the next update off, so the word stays whole
	a_update_defer: assert property (reading
		&& s.cv == adc_port_pkg::CV_IDLE
		|=> s.cv != adc_port_pkg::CV_UPD)
		else $error("update started during a data read");
	a_cal_start: assert property (rise && last
		&& s.ph == adc_port_pkg::PH_DATA && !s.rd
		&& s.rs == adc_port_pkg::RS_MODE
		&& word[adc_port_pkg::MD_CAL_BIT]
		|=> O_RDY_N && s.cv == adc_port_pkg::CV_CAL)
		else $error("calibration start not flagged");
	// A serial word ending in the same cycle takes priority over the end
	a_cal_end: assert property (!stby && !(rise && last)
		&& s.cv == adc_port_pkg::CV_CAL && s.cnt == 8'h00
		|=> !O_RDY_N && s.regs[adc_port_pkg::RS_MODE]
		[adc_port_pkg::MD_LSB+:3] == adc_port_pkg::MD_IDLE)
		else $error("calibration end not flagged");
	a_status_load: assert property (rise && last
		&& s.ph == adc_port_pkg::PH_COMM
		&& comm[2:0] == adc_port_pkg::RS_COMM
		|=> s.sh_out[23] == !$past(s.rdy_n))
		else $error("status byte does not show ready");

	c_data_read: cover property (rise && last && reading);
	c_cal_done: cover property (s.cv == adc_port_pkg::CV_CAL ##1
		s.cv == adc_port_pkg::CV_IDLE);
	c_word_loaded: cover property (pop);
	c_standby: cover property ($rose(stby));
	c_status_read: cover property (rise && last
		&& s.ph == adc_port_pkg::PH_COMM
		&& comm[2:0] == adc_port_pkg::RS_COMM);
endmodule

// *** bench/ser_host.sv ***
// Serial host model that drives the converter port pins
module ser_host (
	input wire logic i_dout,
	output adc_port_pkg::ser_pins_t o_ser
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_ser = adc_port_pkg::PIN_IDLE;
	// Select set once and held across a run of transfers
	task automatic sel(input logic v);
		#20 o_ser.cs_n = v;
		#200;
	endtask
	// Data set on the fall, read mid-high, MSB first; clock parks high
	task automatic shift(input int n, input logic [23:0] d,
		output logic [23:0] q);
		q = '0;
		for (int i = n - 1; i >= 0; i--) begin
			o_ser.sclk = 1'b0;
			o_ser.din = d[i];
			#80 o_ser.sclk = 1'b1;
			#40 q = {q[22:0], i_dout};
			#40;
		end
	endtask
	task automatic stby(input logic v);
		o_ser.standby_n = v;
		#200;
	endtask
endmodule

// *** bench/adc_serial_port_tb_top.sv ***
// Self-checking bench of the converter serial port
module adc_serial_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic cv = 1'b0;
	logic [23:0] cd = '0;
	logic cr, dout, oe_n, rdy_n, pd;
	int fall_cyc = 0;
	logic rdy_d = 1'b1;
	adc_port_pkg::ser_pins_t ser;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int rises = 0;
	logic [23:0] q;
	// Released line shows the inverse of the last bit, never the bit itself
	wire dout_w = oe_n ? ~dout : dout;
	adc_serial_port i_dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_SER(ser),
		.I_CONV_VALID(cv), .I_CONV_DATA(cd), .O_CONV_READY(cr),
		.O_DOUT(dout), .O_DOUT_OE_N(oe_n), .O_RDY_N(rdy_n),
		.O_POWER_DOWN(pd));
	ser_host i_host (.i_dout(dout_w), .o_ser(ser));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		rdy_d <= rdy_n;
		cyc <= cyc + 1;
		if (rdy_n === 1'b1 && rdy_d === 1'b0) begin
			rises <= rises + 1;
		end
		if (rdy_n === 1'b0 && rdy_d === 1'b1) begin
			fall_cyc <= cyc;
		end
		if (cyc == 30000) begin
			error_cnt++;
			finish_test();
		end
	end
	// ********************************
	// Shared tasks
	// ********************************
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] rs, input int n,
		input logic [23:0] d);
		i_host.shift(8, {16'h0, 5'h00, rs}, q);
		i_host.shift(n, d, q);
	endtask
	task automatic rd(input logic [2:0] rs, input int n,
		output logic [23:0] r);
		i_host.shift(8, {16'h0, 5'h08, rs}, r);
		i_host.shift(n, 24'h0, r);
	endtask
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_regs();
		i_host.sel(1'b0);
		wr(adc_port_pkg::RS_FILT, 24, 24'hA5C3F1);
		wr(adc_port_pkg::RS_DAC, 8, 24'h5A);
		wr(adc_port_pkg::RS_DATA, 24, 24'h123456);
		rd(adc_port_pkg::RS_FILT, 24, q);
		chk(q, 24'hA5C3F1);
		rd(adc_port_pkg::RS_DAC, 8, q);
		chk(q, 24'h5A);
		rd(adc_port_pkg::RS_DATA, 24, q);
		chk(q, 24'h0);
		$display("regs done");
	endtask
	task automatic t_desel();
		i_host.sel(1'b1);
		chk(24'(oe_n), 24'h1);
		i_host.shift(8, 24'hFF, q);
		chk(24'(oe_n), 24'h1);
		i_host.sel(1'b0);
		rd(adc_port_pkg::RS_FILT, 24, q);
		chk(q, 24'hA5C3F1);
		$display("deselect done");
	endtask
	task automatic t_stby();
		i_host.stby(1'b0);
		chk(24'(pd), 24'h1);
		i_host.stby(1'b1);
		chk(24'(pd), 24'h0);
		rd(adc_port_pkg::RS_FILT, 24, q);
		chk(q, 24'hA5C3F1);
		$display("standby done");
	endtask
	task automatic t_conv();
		int n;
		int r0;
		n = 0;
		@(posedge clk);
		#1;
		while (n < 12 && cr === 1'b1) begin
			cd = 24'(n + 1);
			cv = 1'b1;
			@(posedge clk);
			#1 n++;
		end
		cv = 1'b0;
		chk(24'(n), 24'(adc_port_pkg::FIFO_DEPTH));
		r0 = rises;
		wr(adc_port_pkg::RS_MODE, 16, 24'h2000);
		repeat (120) @(posedge clk);
		#1;
		chk(24'(rises - r0), 24'h7);
		chk(24'(rdy_n), 24'h0);
		rd(adc_port_pkg::RS_DATA, 24, q);
		chk(q, 24'h8);
		repeat (3) @(posedge clk);
		#1;
		chk(24'(rdy_n), 24'h1);
		$display("conversion done");
	endtask
	task automatic t_cal();
		int k;
		int c0;
		int d;
		wr(adc_port_pkg::RS_MODE, 16, 24'h8000);
		c0 = cyc;
		// Status while busy: ready bit low, calibration flag set
		rd(adc_port_pkg::RS_COMM, 8, q);
		chk(q, 24'h40);
		k = 0;
		while (k < 200 && rdy_n !== 1'b0) begin
			@(posedge clk);
			#1 k++;
		end
		d = fall_cyc - c0;
		chk(24'(d >= 92 && d <= 100), 24'h1);
		rd(adc_port_pkg::RS_COMM, 8, q);
		chk(q, 24'h80);
		rd(adc_port_pkg::RS_MODE, 16, q);
		chk(q, 24'h0);
		$display("calibration done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 srst = 1'b0;
		chk(24'({rdy_n, oe_n, pd}), 24'h6);
		t_regs();
		t_desel();
		t_stby();
		t_conv();
		t_cal();
		finish_test();
	end
endmodule
